// ==== bench/dpa_bridge_model.sv ====
// behavioural peripheral bridge: word memory with wait states and an error window
module dpa_bridge_model
  import dpa_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // downstream_bus from the unit
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  output logic hready,
  output logic [31:0] hrdata,
  output logic hresp,
  // test control and counters
  input wire logic [1:0] wait_n,
  output int n_taken,
  output int n_wr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [0:255];
  logic [31:0] a, last, m;
  logic act, wr, err;
  logic [2:0] sz;
  logic [1:0] cnt;
  // ----------------------------------------------------------------
  // data phase answer
  // ----------------------------------------------------------------
  // error window at offset 0xE00: two-cycle error, never stored
  assign hready = !act ? 1'h1 : err ? (cnt == 2'h1) : (cnt == wait_n);
  assign hresp = act && err;
  // released data bus shows a changing pattern, not the last value
  assign hrdata = (act && hready && !wr && !err) ? mem[a[9:2]] : ~last;
  assign m = (sz == DPA_HSIZE_BYTE) ? 32'h0000_00FF << (8 * a[1:0]) :
             (sz == DPA_HSIZE_HALF) ? 32'h0000_FFFF << (16 * a[1]) : 32'hFFFF_FFFF;
  // ----------------------------------------------------------------
  // address capture and write completion
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      act <= 1'h0;
      cnt <= 2'h0;
      last <= 32'h0000_0000;
      n_taken <= 0;
      n_wr <= 0;
    end else begin
      last <= hrdata;
      if (act && hready && wr && !err) begin
        mem[a[9:2]] <= (mem[a[9:2]] & ~m) | (hwdata & m);
        n_wr <= n_wr + 1;
      end
      if (act && !hready) cnt <= cnt + 2'h1;
      if (hready) begin
        act <= htrans[1];
        a <= haddr;
        wr <= hwrite;
        sz <= hsize;
        err <= (haddr[11:8] == 4'hE);
        cnt <= 2'h0;
        if (htrans[1]) n_taken <= n_taken + 1;
      end
    end
  end
endmodule

// ==== bench/test_decorated_peripheral_access.sv ====
// self-checking bench for the decorated peripheral access unit
module test_decorated_peripheral_access import dpa_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [31:0] d;
    logic chk;
    logic resp;
    logic [7:0] cyc;
  } dpa_exp_type;
  logic clk_sys = 1'h0;
  logic rst_b = 1'h0;
  logic upstream_hsel = 1'h0;
  logic [31:0] upstream_haddr = DPA_RESET_ADDR;
  logic [1:0] upstream_htrans = DPA_HTRANS_IDLE;
  logic upstream_hwrite = 1'h0;
  logic [2:0] upstream_hsize = DPA_HSIZE_WORD;
  logic [31:0] upstream_hwdata = DPA_RESET_DATA;
  logic upstream_from_core = 1'h1;
  logic upstream_hready, upstream_hreadyout, upstream_hresp;
  logic [31:0] upstream_hrdata, downstream_haddr, downstream_hwdata, downstream_hrdata;
  logic [1:0] downstream_htrans;
  logic [2:0] downstream_hsize;
  logic downstream_hwrite, downstream_hready, downstream_hresp;
  logic [1:0] wait_n = 2'h0;
  int n_taken, n_wr, n_errors, samples_checked, i, k0, k1;
  logic [31:0] seed = 32'h0000_0047;
  logic [31:0] sh [0:255];
  logic [31:0] ap_addr, w, m, v, a;
  logic ap_wr;
  logic dphase = 1'h0;
  logic [7:0] cyc = 8'h00;
  logic [4:0] b;
  logic [3:0] wm;
  dpa_exp_type q [$];
  dpa_exp_type e;
  logic [2:0] so [6] = '{DPA_OP_AND, DPA_OP_OR_LAC, DPA_OP_XOR_LAS,
                         DPA_OP_AND, DPA_OP_OR_LAC, DPA_OP_XOR_LAS};
  logic [2:0] ss [6] = '{DPA_HSIZE_WORD, DPA_HSIZE_WORD, DPA_HSIZE_WORD,
                         DPA_HSIZE_BYTE, DPA_HSIZE_HALF, DPA_HSIZE_BYTE};
  logic [4:0] sf [6] = '{5'h00, 5'h04, 5'h08, 5'h0D, 5'h12, 5'h17};
  // refused accesses, flags are write, core, size
  logic [31:0] ea [5] = '{32'h4008_0000, 32'h400E_FFFC, 32'h4400_0010, 32'h4400_0010,
                          32'h4800_0010};
  logic [4:0] eb [5] = '{5'h1A, 5'h0A, 5'h12, 5'h0A, 5'h1B};
  // ----------------------------------------------------------------
  // clock, design and bridge
  // ----------------------------------------------------------------
  always #2.5 clk_sys = ~clk_sys;
  assign upstream_hready = upstream_hreadyout;
  dpa_unit dut_u (.clk_sys, .rst_b, .upstream_hsel, .upstream_haddr, .upstream_htrans,
    .upstream_hwrite, .upstream_hsize, .upstream_hwdata, .upstream_hready,
    .upstream_from_core, .upstream_hreadyout, .upstream_hrdata, .upstream_hresp,
    .downstream_haddr, .downstream_htrans, .downstream_hwrite, .downstream_hsize,
    .downstream_hwdata, .downstream_hready, .downstream_hrdata, .downstream_hresp);
  dpa_bridge_model bridge_u (.clk_sys, .rst_b, .haddr(downstream_haddr),
    .htrans(downstream_htrans), .hwrite(downstream_hwrite), .hsize(downstream_hsize),
    .hwdata(downstream_hwdata), .hready(downstream_hready), .hrdata(downstream_hrdata),
    .hresp(downstream_hresp), .wait_n, .n_taken, .n_wr);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic dpa_exp_type mk(logic [31:0] d, logic c, logic r, logic [7:0] n);
    mk = '{d, c, r, n};
  endfunction
  task chk_word(input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, x, g);
    end
  endtask
  task chk_small(input logic [7:0] x, input logic [7:0] g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t exp %h got %h", $time, x, g);
    end
  endtask
  // one transfer at a time; the idle cycle after it keeps phases apart
  task automatic xfer(logic [31:0] ad, logic wr, logic [2:0] sz, logic core,
      logic [31:0] wd, dpa_exp_type ex);
    int k;
    @(negedge clk_sys);
    upstream_hsel = 1'h1;
    upstream_haddr = ad;
    upstream_htrans = DPA_HTRANS_NONSEQ;
    upstream_hwrite = wr;
    upstream_hsize = sz;
    upstream_from_core = core;
    #2;
    ap_addr = downstream_haddr;
    ap_wr = downstream_hwrite;
    q.push_back(ex);
    @(negedge clk_sys);
    upstream_hsel = 1'h0;
    upstream_htrans = DPA_HTRANS_IDLE;
    upstream_hwdata = wd;
    dphase = 1'h1;
    k = 0;
    #2;
    while (upstream_hreadyout !== 1'h1 && k < 60) begin
      @(negedge clk_sys);
      #2;
      k++;
    end
    if (k >= 60) begin
      n_errors++;
    end
    @(negedge clk_sys);
    dphase = 1'h0;
  endtask
  task stop_test();
    $display("compared %0d, mismatched %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // response monitor
  // ----------------------------------------------------------------
  initial forever begin
    @(negedge clk_sys);
    #2;
    if (dphase) begin
      cyc = cyc + 8'h01;
      if (upstream_hreadyout === 1'h1) begin
        e = q.pop_front();
        if (e.chk) chk_word(e.d, upstream_hrdata);
        chk_small({7'h00, e.resp}, {7'h00, upstream_hresp});
        chk_small(e.cyc, cyc);
        cyc = 8'h00;
      end
    end
  end
  initial begin
    #40000;
    n_errors++;
    stop_test();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'h1;
    for (i = 0; i < 8; i++) begin
      sh[i] = rnd();
      xfer(DPA_PERIPH_BASE | (i * 4), 1'h1, DPA_HSIZE_WORD, 1'h1, sh[i],
           mk(0, 0, 0, 1));
      chk_word(DPA_PERIPH_BASE | (i * 4), ap_addr);
    end
    for (i = 0; i < 8; i++) begin
      wait_n = 2'(i % 3);
      xfer(DPA_PERIPH_BASE | (i * 4), 0, DPA_HSIZE_WORD, 1, 0,
           mk(sh[i], 1, 0, 8'(i % 3 + 1)));
    end
    for (i = 0; i < 6; i++) begin
      wait_n = 2'(i % 3);
      w = rnd();
      w = (ss[i] == DPA_HSIZE_BYTE) ? {4{w[7:0]}} : (ss[i] == DPA_HSIZE_HALF) ? {2{w[15:0]}} : w;
      a = {27'h000_0000, sf[i]};
      v = (so[i] == DPA_OP_AND) ? sh[i] & w : (so[i] == DPA_OP_OR_LAC) ? sh[i] | w : sh[i] ^ w;
      m = (ss[i] == DPA_HSIZE_BYTE) ? 32'h0000_00FF << (8 * a[1:0]) :
          (ss[i] == DPA_HSIZE_HALF) ? 32'h0000_FFFF << (16 * a[1]) : 32'hFFFF_FFFF;
      xfer({DPA_DEC_TOP, so[i], 6'h00, a[19:0]}, 1, ss[i], 1, w,
           mk(0, 0, 0, 8'(2 * (i % 3) + 2)));
      chk_word(DPA_PERIPH_BASE | a, ap_addr);
      chk_small(8'h00, {7'h00, ap_wr});
      sh[i] = (sh[i] & ~m) | (v & m);
      wait_n = 2'h0;
      xfer(DPA_PERIPH_BASE | (i * 4), 0, DPA_HSIZE_WORD, 1, 0, mk(sh[i], 1, 0, 1));
    end
    for (i = 2; i < 4; i++) begin
      v = rnd();
      b = v[4:0];
      xfer({DPA_DEC_TOP, 3'(i), b, 1'h0, 20'h0_0018}, 0, DPA_HSIZE_WORD, 1, 0,
           mk({31'h0, sh[6][b]}, 1, 0, 2));
      sh[6][b] = (i == 3);
      xfer(DPA_PERIPH_BASE | 32'h18, 0, DPA_HSIZE_WORD, 1, 0, mk(sh[6], 1, 0, 1));
    end
    // even width-1 keeps address bit 19 clear, away from the gap
    v = rnd();
    b = v[4:0];
    wm = {v[7:5], 1'h0};
    m = (32'h1 << (wm + 1)) - 1;
    a = {DPA_DEC_TOP, 1'h1, b, wm, 19'h0_001C};
    xfer(a, 0, DPA_HSIZE_WORD, 1, 0, mk((sh[7] >> b) & m, 1, 0, 1));
    w = rnd();
    xfer(a, 1, DPA_HSIZE_WORD, 1, w, mk(0, 0, 0, 2));
    sh[7] = (sh[7] & ~(m << b)) | (w & (m << b));
    xfer(DPA_PERIPH_BASE | 32'h1C, 0, DPA_HSIZE_WORD, 1, 0, mk(sh[7], 1, 0, 1));
    k0 = n_taken;
    k1 = n_wr;
    for (i = 0; i < 5; i++) begin
      xfer(ea[i], eb[i][4], eb[i][2:0], eb[i][3], rnd(), mk(0, 0, 1, 2));
    end
    chk_word(k0, n_taken);
    xfer(32'h4400_0E00, 1, DPA_HSIZE_WORD, 1, 0, mk(0, 0, 1, 2));
    chk_word(k1, n_wr);
    xfer(32'h4000_0E00, 0, DPA_HSIZE_WORD, 1, 0, mk(0, 0, 1, 2));
    xfer(32'h400F_F000, 0, DPA_HSIZE_WORD, 1, 0, mk(sh[0], 1, 0, 1));
    chk_word(32'h0000_0000, q.size());
    stop_test();
  end
endmodule

// ==== design/dpa_pkg.sv ====
// constants and types for the decorated peripheral access unit
package dpa_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [31:0] DPA_PERIPH_BASE = 32'h4000_0000;
  localparam logic [31:0] DPA_GAP_LO = 32'h4008_0000;
  localparam logic [31:0] DPA_GAP_HI = 32'h400E_FFFF;
  localparam logic [2:0] DPA_DEC_TOP = 3'h2;
  localparam int DPA_TOP_HI = 31;
  localparam int DPA_TOP_LO = 29;
  localparam int DPA_SEM_HI = 28;
  localparam int DPA_SEM_LO = 19;
  localparam int DPA_OP_HI = 28;
  localparam int DPA_OP_LO = 26;
  localparam int DPA_MEM_W = 20;
  localparam int DPA_BIT_HI = 25;
  localparam int DPA_BIT_LO = 21;
  localparam int DPA_BFP_HI = 27;
  localparam int DPA_BFP_LO = 23;
  localparam int DPA_BFW_HI = 22;
  localparam int DPA_BFW_LO = 19;

  // ----------------------------------------------------------------
  // operation codes in the decoration field
  // ----------------------------------------------------------------
  localparam logic [2:0] DPA_OP_NONE = 3'h0;
  localparam logic [2:0] DPA_OP_AND = 3'h1;
  localparam logic [2:0] DPA_OP_OR_LAC = 3'h2;
  localparam logic [2:0] DPA_OP_XOR_LAS = 3'h3;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] DPA_HTRANS_IDLE = 2'h0;
  localparam logic [1:0] DPA_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] DPA_HSIZE_BYTE = 3'h0;
  localparam logic [2:0] DPA_HSIZE_HALF = 3'h1;
  localparam logic [2:0] DPA_HSIZE_WORD = 3'h2;
  localparam logic [31:0] DPA_RESET_ADDR = 32'h0000_0000;
  localparam logic [31:0] DPA_RESET_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    DPA_ST_IDLE = 3'b000,
    DPA_ST_PASS = 3'b001,
    DPA_ST_XTRACT = 3'b010,
    DPA_ST_RMW1 = 3'b011,
    DPA_ST_RMW2 = 3'b100,
    DPA_ST_ERR1 = 3'b101,
    DPA_ST_ERR2 = 3'b110
  } dpa_state_type;

  // captured address-phase attributes of a decorated access
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] size;
    logic write;
    logic [2:0] op;
    logic [4:0] pos;
    logic [4:0] wm1;
  } dpa_req_type;

  localparam dpa_req_type DPA_REQ_RESET = '0;

endpackage

// ==== design/dpa_unit.sv ====
// decorated peripheral access unit: ahb pipeline stage with atomic read-modify-write
// Summary of operation
// - decoration honoured only for core accesses
// - operation semantic taken from address bits 28:19
// - 0x4400_0000..0x5FFF_FFFF is decorated space
// - strip decoration from forwarded address
// - peripheral space 512 KB plus 64 KB
// - gap 0x4008_0000..0x400E_FFFF gets error
// - ahb slave in, ahb master out
// - two stages: address phase, data phase
// - plain accesses pass through combinationally
// - decorated access other than field extract becomes read then write
// - loads: field extract, load-and-set, load-and-clear
// - stores: field insert, and, or, xor
// - byte, halfword and word sizes supported
// - keep idle output bus steady
// - behaviour set by address only
// - one clock domain throughout
// - both buses ahb, 32-bit data
// - drive upstream response, take downstream response
// - no software registers
// - store: modify in first, write in second
// - decoration 001 selects logical and
// - downstream wait states stall upstream equally
module dpa_unit
  import dpa_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // upstream_bus: slave side toward the crossbar
  input wire logic upstream_hsel,
  input wire logic [31:0] upstream_haddr,
  input wire logic [1:0] upstream_htrans,
  input wire logic upstream_hwrite,
  input wire logic [2:0] upstream_hsize,
  input wire logic [31:0] upstream_hwdata,
  input wire logic upstream_hready,
  input wire logic upstream_from_core,
  output logic upstream_hreadyout,
  output logic [31:0] upstream_hrdata,
  output logic upstream_hresp,
  // downstream_bus: master side toward periph_bus_bridge
  output logic [31:0] downstream_haddr,
  output logic [1:0] downstream_htrans,
  output logic downstream_hwrite,
  output logic [2:0] downstream_hsize,
  output logic [31:0] downstream_hwdata,
  input wire logic downstream_hready,
  input wire logic [31:0] downstream_hrdata,
  input wire logic downstream_hresp
);

  // ----------------------------------------------------------------
  // lane and field helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] lane_shift(input logic [2:0] size, input logic [1:0] lane);
    if (size == DPA_HSIZE_BYTE) begin
      return {lane, 3'b000};
    end else if (size == DPA_HSIZE_HALF) begin
      return {lane[1], 4'b0000};
    end
    return 5'd0;
  endfunction

  function automatic logic [31:0] size_mask(input logic [2:0] size);
    if (size == DPA_HSIZE_BYTE) begin
      return 32'h0000_00FF;
    end else if (size == DPA_HSIZE_HALF) begin
      return 32'h0000_FFFF;
    end
    return 32'hFFFF_FFFF;
  endfunction

  // mask of wm1+1 bits at pos inside the operand, moved to its byte lane
  function automatic logic [31:0] field_mask(input dpa_req_type r);
    logic [63:0] f;
    f = ((64'h1 << (6'(r.wm1) + 6'd1)) - 64'h1) << r.pos;
    return (f[31:0] & size_mask(r.size)) << lane_shift(r.size, r.addr[1:0]);
  endfunction

  // unsigned extract, result placed at the low end of the operand lane
  function automatic logic [31:0] extract(input dpa_req_type r, input logic [31:0] rd);
    logic [4:0] sh;
    logic [63:0] w;
    sh = lane_shift(r.size, r.addr[1:0]);
    w = (64'h1 << (6'(r.wm1) + 6'd1)) - 64'h1;
    return (((rd >> sh) >> r.pos) & w[31:0] & size_mask(r.size)) << sh;
  endfunction

  // ----------------------------------------------------------------
  // address-phase decode of the incoming request
  // ----------------------------------------------------------------
  dpa_state_type state;
  dpa_state_type next_state;
  dpa_req_type cap;
  dpa_req_type in_req;
  logic [31:0] rmw_wdata;
  logic [31:0] load_rdata;
  logic [31:0] held_addr;
  logic [2:0] held_size;
  logic held_write;
  logic [2:0] in_op;
  logic in_dec;
  logic [31:0] in_mem;
  logic in_gap;
  logic in_bad;
  logic open_state;
  logic accept;
  logic in_rmw;
  assign in_op = upstream_haddr[DPA_OP_HI:DPA_OP_LO];
  // decorated space is the 448 MB alias above the periph window
  assign in_dec = (upstream_haddr[DPA_TOP_HI:DPA_TOP_LO] == DPA_DEC_TOP)
                  && (in_op != DPA_OP_NONE);
  // decoration is dropped: only mem_addr reaches the bridge
  assign in_mem = in_dec ? (DPA_PERIPH_BASE | 32'(upstream_haddr[DPA_MEM_W-1:0]))
                         : upstream_haddr;
  assign in_gap = (in_mem >= DPA_GAP_LO) && (in_mem <= DPA_GAP_HI);
  // and-decoration has no load meaning; only core may decorate
  assign in_bad = in_gap
                  || (in_dec && !upstream_from_core)
                  || (in_dec && !upstream_hwrite && in_op == DPA_OP_AND)
                  || (in_dec && upstream_hsize > DPA_HSIZE_WORD);
  assign open_state = (state == DPA_ST_IDLE) || (state == DPA_ST_PASS)
                      || (state == DPA_ST_XTRACT) || (state == DPA_ST_RMW2)
                      || (state == DPA_ST_ERR2);
  assign accept = open_state && upstream_hsel && upstream_htrans[1] && upstream_hready;
  // field extract is the only decorated access with no write-back
  assign in_rmw = upstream_hwrite || !in_op[2];

  always_comb begin
    in_req = DPA_REQ_RESET;
    in_req.addr = in_mem;
    in_req.size = upstream_hsize;
    in_req.write = upstream_hwrite;
    in_req.op = in_op;
    if (in_op[2]) begin
      in_req.pos = upstream_haddr[DPA_BFP_HI:DPA_BFP_LO];
      in_req.wm1 = {1'b0, upstream_haddr[DPA_BFW_HI:DPA_BFW_LO]};
    end else begin
      in_req.pos = upstream_haddr[DPA_BIT_HI:DPA_BIT_LO];
      in_req.wm1 = 5'd0;
    end
  end

  // ----------------------------------------------------------------
  // pipeline state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      DPA_ST_IDLE, DPA_ST_PASS, DPA_ST_XTRACT, DPA_ST_RMW2, DPA_ST_ERR2: begin
        if (accept) begin
          if (in_bad) begin
            next_state = DPA_ST_ERR1;
          end else if (in_dec && in_rmw) begin
            next_state = DPA_ST_RMW1;
          end else if (in_dec) begin
            next_state = DPA_ST_XTRACT;
          end else begin
            next_state = DPA_ST_PASS;
          end
        end else if (upstream_hready) begin
          next_state = DPA_ST_IDLE;
        end
      end
      DPA_ST_RMW1: begin
        // a failed read aborts the write-back
        if (downstream_hresp) begin
          next_state = DPA_ST_ERR2;
        end else if (downstream_hready) begin
          next_state = DPA_ST_RMW2;
        end
      end
      DPA_ST_ERR1: begin
        next_state = DPA_ST_ERR2;
      end
      default: begin
        next_state = DPA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= DPA_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cap <= DPA_REQ_RESET;
    end else if (accept) begin
      cap <= in_req;
    end
  end

  // ----------------------------------------------------------------
  // modify step: runs in the read data phase
  // ----------------------------------------------------------------
  logic [31:0] fmask;
  logic [31:0] next_wdata;
  logic [31:0] next_rdata;
  assign fmask = field_mask(cap);
  always_comb begin
    next_wdata = downstream_hrdata;
    next_rdata = DPA_RESET_DATA;
    if (cap.write) begin
      if (cap.op[2]) begin
        next_wdata = (downstream_hrdata & ~fmask) | (upstream_hwdata & fmask);
      end else if (cap.op == DPA_OP_AND) begin
        next_wdata = downstream_hrdata & upstream_hwdata;
      end else if (cap.op == DPA_OP_OR_LAC) begin
        next_wdata = downstream_hrdata | upstream_hwdata;
      end else begin
        next_wdata = downstream_hrdata ^ upstream_hwdata;
      end
    end else begin
      // the old bit is returned, the new value written back
      next_rdata = extract(cap, downstream_hrdata);
      if (cap.op == DPA_OP_OR_LAC) begin
        next_wdata = downstream_hrdata & ~fmask;
      end else begin
        next_wdata = downstream_hrdata | fmask;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rmw_wdata <= DPA_RESET_DATA;
      load_rdata <= DPA_RESET_DATA;
    end else if (state == DPA_ST_RMW1 && downstream_hready) begin
      rmw_wdata <= next_wdata;
      load_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // downstream address phase
  // ----------------------------------------------------------------
  // plain requests go out in the same cycle, so these outputs are combinational
  always_comb begin
    downstream_haddr = held_addr;
    downstream_hsize = held_size;
    downstream_hwrite = held_write;
    downstream_htrans = DPA_HTRANS_IDLE;
    if (accept && !in_bad) begin
      downstream_haddr = in_mem;
      downstream_hsize = upstream_hsize;
      downstream_hwrite = upstream_hwrite && !in_dec;
      downstream_htrans = DPA_HTRANS_NONSEQ;
    end else if (state == DPA_ST_RMW1 && !downstream_hresp) begin
      downstream_haddr = cap.addr;
      downstream_hsize = cap.size;
      downstream_hwrite = 1'b1;
      downstream_htrans = DPA_HTRANS_NONSEQ;
    end
  end

  // last address and control are replayed while idle to save toggles
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      held_addr <= DPA_RESET_ADDR;
      held_size <= DPA_HSIZE_BYTE;
      held_write <= 1'b0;
    end else begin
      held_addr <= downstream_haddr;
      held_size <= downstream_hsize;
      held_write <= downstream_hwrite;
    end
  end
  assign downstream_hwdata = (state == DPA_ST_RMW2) ? rmw_wdata : upstream_hwdata;

  // ----------------------------------------------------------------
  // upstream data phase response
  // ----------------------------------------------------------------
  always_comb begin
    upstream_hreadyout = 1'b1;
    upstream_hresp = 1'b0;
    upstream_hrdata = downstream_hrdata;
    unique case (state)
      DPA_ST_PASS: begin
        upstream_hreadyout = downstream_hready;
        upstream_hresp = downstream_hresp;
      end
      DPA_ST_XTRACT: begin
        upstream_hreadyout = downstream_hready;
        upstream_hresp = downstream_hresp;
        upstream_hrdata = extract(cap, downstream_hrdata);
      end
      DPA_ST_RMW1: begin
        upstream_hreadyout = 1'b0;
        upstream_hresp = downstream_hresp;
      end
      DPA_ST_RMW2: begin
        upstream_hreadyout = downstream_hready;
        upstream_hresp = downstream_hresp;
        upstream_hrdata = load_rdata;
      end
      DPA_ST_ERR1: begin
        upstream_hreadyout = 1'b0;
        upstream_hresp = 1'b1;
      end
      DPA_ST_ERR2: begin
        upstream_hreadyout = 1'b1;
        upstream_hresp = 1'b1;
      end
      default: begin
        upstream_hreadyout = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dpa_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  property p_strip;
    accept && in_dec && !in_bad |->
      downstream_haddr[31:20] == 12'h400 && downstream_haddr[19:0] == upstream_haddr[19:0];
  endproperty
  a_strip: assert property (p_strip) else $error("decoration not stripped");
  property p_pass;
    accept && !in_dec && !in_bad |-> downstream_htrans == DPA_HTRANS_NONSEQ
      && downstream_haddr == upstream_haddr && downstream_hwrite == upstream_hwrite;
  endproperty
  a_pass: assert property (p_pass) else $error("plain access not forwarded");
  property p_dec_read;
    accept && in_dec && !in_bad |-> !downstream_hwrite ##1 state != DPA_ST_IDLE;
  endproperty
  a_dec_read: assert property (p_dec_read) else $error("decorated access not a read");
  property p_rmw_write;
    state == DPA_ST_RMW1 && !downstream_hresp |->
      downstream_htrans == DPA_HTRANS_NONSEQ && downstream_hwrite && !upstream_hreadyout;
  endproperty
  a_rmw_write: assert property (p_rmw_write) else $error("write-back missing");
  property p_and;
    state == DPA_ST_RMW1 && downstream_hready && !downstream_hresp
      && cap.write && cap.op == DPA_OP_AND |=>
      downstream_hwdata == ($past(downstream_hrdata) & $past(upstream_hwdata));
  endproperty
  a_and: assert property (p_and) else $error("and result wrong");
  property p_gap;
    accept && in_gap |-> downstream_htrans == DPA_HTRANS_IDLE
      ##1 (!upstream_hreadyout && upstream_hresp) ##1 (upstream_hreadyout && upstream_hresp);
  endproperty
  a_gap: assert property (p_gap) else $error("gap access not errored");
  property p_wait;
    state == DPA_ST_PASS || state == DPA_ST_RMW2 |-> upstream_hreadyout == downstream_hready;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not forwarded");
  property p_steady;
    downstream_htrans == DPA_HTRANS_IDLE && $past(downstream_htrans) == DPA_HTRANS_IDLE
      |-> $stable(downstream_haddr);
  endproperty
  a_steady: assert property (p_steady) else $error("idle address toggled");
  property p_noncore;
    accept && in_dec && !upstream_from_core |-> downstream_htrans == DPA_HTRANS_IDLE
      ##1 state == DPA_ST_ERR1;
  endproperty
  a_noncore: assert property (p_noncore) else $error("non-core decoration accepted");
endmodule
